// ===== hdl/fwrp_pkg.sv
package fwrp_pkg;

    // ****************************************************************
    // Address map of the flash regions seen by the CPU.
    // ****************************************************************
    localparam logic [23:0] FWRP_PROG_BASE       = 24'h000000;
    localparam logic [23:0] FWRP_PROG_TOP        = 24'h03FFFF;
    localparam logic [23:0] FWRP_DATA_BASE       = 24'h0E0000;
    localparam logic [23:0] FWRP_DATA_TOP        = 24'h0E1FFF;
    localparam logic [23:0] FWRP_BOOT_END_MAX    = 24'h001BFF;

    // Section sizes are 8K bytes in program flash, 512 bytes in data flash.
    localparam int          FWRP_PROG_SECT_LSB   = 13;
    localparam int          FWRP_DATA_SECT_LSB   = 9;
    localparam int          FWRP_SECTS_PER_REG   = 16;

    // ****************************************************************
    // Register offsets on the software port (byte addresses).
    // ****************************************************************
    localparam logic [23:0] FWRP_OFS_PROG_EN_LOW  = 24'hFFF900;
    localparam logic [23:0] FWRP_OFS_PROG_EN_HIGH = 24'hFFF904;
    localparam logic [23:0] FWRP_OFS_DATA_EN      = 24'hFFF908;
    localparam logic [23:0] FWRP_OFS_STATUS       = 24'hFFF914;

    // Reset values: every section starts closed for CPU writes.
    localparam logic [15:0] FWRP_SECT_EN_RESET   = 16'h0000;
    localparam logic [7:0]  FWRP_STATUS_RESET    = 8'h00;

    // ****************************************************************
    // Status byte layout.
    // ****************************************************************
    localparam int          FWRP_STAT_ENV_LSB    = 0;
    localparam int          FWRP_STAT_ANY_BUSY   = 3;
    localparam int          FWRP_STAT_DATA_BUSY  = 4;

    // ****************************************************************
    // Protection word layout as stored in nonvolatile flash.
    // ****************************************************************
    localparam int          FWRP_PW_WRLOCK_LSB   = 0;
    localparam int          FWRP_PW_RDLOCK_LSB   = 3;
    localparam int          FWRP_PW_BOOT_LSB     = 6;
    localparam int          FWRP_PW_BOOT_W       = 3;
    localparam int          FWRP_BOOT_UNIT_LSB   = 10;

    // The lock is active when most of the three stored bits are zero.
    function automatic logic fwrp_majority_zero(input logic [2:0] f);
        fwrp_majority_zero = (~f[0] & ~f[1]) | (~f[0] & ~f[2]) | (~f[1] & ~f[2]);
    endfunction

endpackage

// ===== hdl/fwrp_prot_if.sv
`timescale 1ns/100ps
// Lock state decoded from the protection word, shared with the top.
interface fwrp_prot_if;
    logic        write_lock;
    logic        read_lock;
    logic [23:0] boot_end;
    logic        loaded;

    modport loader (output write_lock, output read_lock, output boot_end, output loaded);
    modport user   (input  write_lock, input  read_lock, input  boot_end, input  loaded);
endinterface

// ===== hdl/fwrp_prot_load.sv
`timescale 1ns/100ps
module fwrp_prot_load
    import fwrp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [15:0] prot_word_nv,
    fwrp_prot_if.loader      prot
);

    logic [FWRP_PW_BOOT_W-1:0] boot_units;

    assign boot_units = prot_word_nv[FWRP_PW_BOOT_LSB +: FWRP_PW_BOOT_W];

    // The word is taken once after reset release, so a rewrite counts only
    // after the next reset; both locks stay active until it is taken.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prot.loaded     <= 1'b0;
            prot.write_lock <= 1'b1;
            prot.read_lock  <= 1'b1;
            prot.boot_end   <= FWRP_BOOT_END_MAX + 24'h000001;
        end else if (!prot.loaded) begin
            prot.loaded     <= 1'b1;
            prot.write_lock <= fwrp_majority_zero(prot_word_nv[FWRP_PW_WRLOCK_LSB +: 3]);
            prot.read_lock  <= fwrp_majority_zero(prot_word_nv[FWRP_PW_RDLOCK_LSB +: 3]);
            prot.boot_end   <= {11'h000, boot_units, 10'h000};
        end
    end

endmodule

// ===== hdl/fwrp_sync.sv
`timescale 1ns/100ps
module fwrp_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_width_check
        $error("fwrp_sync: WIDTH must be at least 1.");
    end

    // Two flops; the first one is read by the second alone.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ===== hdl/fwrp_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Boot region from zero to programmable end.
// - CPU writes into boot region always refused.
// - Code region writes need section enable, unlocked.
// - Data flash writes need section enable, unlocked.
// - Sections are 8K program, 512 data bytes.
// - Section enables clear at reset, writes closed.
// - Software sets enable bits to open sections.
// - Majority-zero write field locks all CPU writes.
// - Majority-zero read field blocks debugger reads.
// - CPU reads never affected by read lock.
// - Lock state comes from stored nonvolatile word.
// - Status low bits show sampled environment pins.
// - Any-busy bit set while either array busy.
// - Data-busy bit set during data flash operation.
// - Protection word changes apply after next reset.
module fwrp_top
    import fwrp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    // Software register port.
    input  wire logic [23:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // CPU write path toward the flash arrays.
    input  wire logic        cpu_wr_req,
    input  wire logic [23:0] cpu_wr_addr,
    input  wire logic [15:0] cpu_wr_data,
    output logic             flash_wr_req,
    output logic      [23:0] flash_wr_addr,
    output logic      [15:0] flash_wr_data,
    output logic             cpu_wr_refused,
    // CPU read path.
    input  wire logic        cpu_rd_req,
    input  wire logic [23:0] cpu_rd_addr,
    output logic             flash_cpu_rd_req,
    output logic      [23:0] flash_cpu_rd_addr,
    // Debug and programmer read path.
    input  wire logic        dbg_rd_req,
    input  wire logic [23:0] dbg_rd_addr,
    output logic             flash_dbg_rd_req,
    output logic      [23:0] flash_dbg_rd_addr,
    output logic             dbg_rd_refused,
    // Flash array state and stored protection word.
    input  wire logic        prog_flash_busy,
    input  wire logic        data_flash_busy,
    input  wire logic [15:0] prot_word_nv,
    // Environment select pins.
    input  wire logic [2:0]  environment_select_inputs,
    // Decoded lock state, for observation.
    output logic             write_lock_active,
    output logic             read_lock_active
);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    fwrp_prot_if prot ();

    logic [15:0] program_section_enable_low_reg;
    logic [15:0] program_section_enable_high_reg;
    logic [15:0] data_section_enable_reg;
    logic [7:0]  module_status_byte_reg;
    logic [2:0]  env_sync;
    logic [2:0]  sampled_environment_bits_reg;
    logic        env_taken_reg;
    logic        env_ready_reg;
    logic        wr_allowed;
    logic        in_boot;
    logic        in_prog;
    logic        in_data;
    logic        sect_open;
    logic [15:0] reg_rdata_next;

    // ****************************************************************
    // Section decoding.
    // ****************************************************************

    // Picks the enable bit that governs a section; used by both regions.
    function automatic logic sect_bit(input logic [15:0] en, input logic [3:0] idx);
        sect_bit = en[idx];
    endfunction

    // True when the address falls in the given inclusive range.
    function automatic logic in_range(input logic [23:0] a,
                                      input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // ****************************************************************
    // Submodules.
    // ****************************************************************

    // The stored word lies outside the register map.
    fwrp_prot_load u_prot_load (
        .clock        (clock),
        .resetn       (resetn),
        .prot_word_nv (prot_word_nv),
        .prot         (prot.loader)
    );

    // Pins come from outside the clock domain.
    fwrp_sync #(
        .WIDTH (3)
    ) u_env_sync (
        .clock    (clock),
        .resetn   (resetn),
        .async_in (environment_select_inputs),
        .sync_out (env_sync)
    );

    // ****************************************************************
    // Write permission check.
    // ****************************************************************

    // The boot region starts at zero and ends below boot_end.
    assign in_boot = (cpu_wr_addr < prot.boot_end);
    assign in_prog = in_range(cpu_wr_addr, FWRP_PROG_BASE, FWRP_PROG_TOP);
    assign in_data = in_range(cpu_wr_addr, FWRP_DATA_BASE, FWRP_DATA_TOP);

    // Bit 17 picks the program enable register.
    always_comb begin
        sect_open = 1'b0;
        if (in_prog) begin
            if (cpu_wr_addr[FWRP_PROG_SECT_LSB + 4]) begin
                sect_open = sect_bit(program_section_enable_high_reg,
                                     cpu_wr_addr[FWRP_PROG_SECT_LSB +: 4]);
            end else begin
                sect_open = sect_bit(program_section_enable_low_reg,
                                     cpu_wr_addr[FWRP_PROG_SECT_LSB +: 4]);
            end
        end else if (in_data) begin
            sect_open = sect_bit(data_section_enable_reg,
                                 cpu_wr_addr[FWRP_DATA_SECT_LSB +: 4]);
        end
    end

    // Boot writes fail whatever the enables say; the global lock overrides
    // every section enable.
    assign wr_allowed = sect_open && !in_boot && !prot.write_lock && prot.loaded;

    // ****************************************************************
    // Forwarding of CPU writes.
    // ****************************************************************

    // A refused write never reaches the arrays, so nothing changes.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flash_wr_req   <= 1'b0;
            flash_wr_addr  <= 24'h000000;
            flash_wr_data  <= 16'h0000;
            cpu_wr_refused <= 1'b0;
        end else begin
            flash_wr_req   <= cpu_wr_req && wr_allowed;
            cpu_wr_refused <= cpu_wr_req && !wr_allowed;
            if (cpu_wr_req && wr_allowed) begin
                flash_wr_addr <= cpu_wr_addr;
                flash_wr_data <= cpu_wr_data;
            end
        end
    end

    // ****************************************************************
    // Read paths.
    // ****************************************************************

    // CPU reads pass through untouched; the read lock is not consulted.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flash_cpu_rd_req  <= 1'b0;
            flash_cpu_rd_addr <= 24'h000000;
        end else begin
            flash_cpu_rd_req <= cpu_rd_req;
            if (cpu_rd_req) begin
                flash_cpu_rd_addr <= cpu_rd_addr;
            end
        end
    end

    // Debug reads stop under the read lock, which reads active until
    // the word is loaded, so nothing leaks after reset.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flash_dbg_rd_req  <= 1'b0;
            flash_dbg_rd_addr <= 24'h000000;
            dbg_rd_refused    <= 1'b0;
        end else begin
            flash_dbg_rd_req <= dbg_rd_req && !prot.read_lock;
            dbg_rd_refused   <= dbg_rd_req && prot.read_lock;
            if (dbg_rd_req && !prot.read_lock) begin
                flash_dbg_rd_addr <= dbg_rd_addr;
            end
        end
    end

    // Lock flags shown at the ports for system use.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            write_lock_active <= 1'b1;
            read_lock_active  <= 1'b1;
        end else begin
            write_lock_active <= prot.write_lock;
            read_lock_active  <= prot.read_lock;
        end
    end

    // ****************************************************************
    // Section enable registers.
    // ****************************************************************

    // All bits clear at reset; clearing after use and waiting for idle
    // arrays is left to software.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            program_section_enable_low_reg  <= FWRP_SECT_EN_RESET;
            program_section_enable_high_reg <= FWRP_SECT_EN_RESET;
            data_section_enable_reg         <= FWRP_SECT_EN_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                FWRP_OFS_PROG_EN_LOW: begin
                    program_section_enable_low_reg <= reg_wdata;
                end
                FWRP_OFS_PROG_EN_HIGH: begin
                    program_section_enable_high_reg <= reg_wdata;
                end
                FWRP_OFS_DATA_EN: begin
                    data_section_enable_reg <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Status byte.
    // ****************************************************************

    // Pins are taken once, two cycles after the word loads, when the second
    // synchroniser flop already holds them; later changes are ignored.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            env_ready_reg                <= 1'b0;
            env_taken_reg                <= 1'b0;
            sampled_environment_bits_reg <= 3'h0;
        end else begin
            env_ready_reg <= prot.loaded;
            if (!env_taken_reg && env_ready_reg) begin
                env_taken_reg                <= 1'b1;
                sampled_environment_bits_reg <= env_sync;
            end
        end
    end

    // Busy flags follow the arrays with one cycle of delay.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            module_status_byte_reg <= FWRP_STATUS_RESET;
        end else begin
            module_status_byte_reg <= FWRP_STATUS_RESET;
            module_status_byte_reg[FWRP_STAT_ENV_LSB +: 3] <= sampled_environment_bits_reg;
            module_status_byte_reg[FWRP_STAT_ANY_BUSY] <=
                prog_flash_busy | data_flash_busy;
            module_status_byte_reg[FWRP_STAT_DATA_BUSY] <= data_flash_busy;
        end
    end

    // ****************************************************************
    // Register read port.
    // ****************************************************************

    // Writes to the status byte are ignored since it is read-only;
    // unmapped reads return zero.
    always_comb begin
        reg_rdata_next = 16'h0000;
        unique case (reg_addr)
            FWRP_OFS_PROG_EN_LOW:  reg_rdata_next = program_section_enable_low_reg;
            FWRP_OFS_PROG_EN_HIGH: reg_rdata_next = program_section_enable_high_reg;
            FWRP_OFS_DATA_EN:      reg_rdata_next = data_section_enable_reg;
            FWRP_OFS_STATUS:       reg_rdata_next = {8'h00, module_status_byte_reg};
            default:               reg_rdata_next = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= reg_rdata_next;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule

// ===== tb/fwrp_flash_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Flash arrays: busy for a while after each forwarded write.
// ****************************************************************
module fwrp_flash_model #(
    parameter int BUSY_CYC = 8
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        flash_wr_req,
    input  wire logic [23:0] flash_wr_addr,
    output logic             prog_flash_busy,
    output logic             data_flash_busy
);
    logic [3:0] left_reg;
    logic       data_reg;

    // Only a forwarded request starts an operation in the array.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            left_reg <= 4'h0;
            data_reg <= 1'b0;
        end else if (flash_wr_req) begin
            left_reg <= 4'(BUSY_CYC);
            data_reg <= (flash_wr_addr[23:16] == 8'h0E);
        end else if (left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
        end
    end

    // Busy levels as the arrays report them.
    assign prog_flash_busy = (left_reg != 4'h0) && !data_reg;
    assign data_flash_busy = (left_reg != 4'h0) && data_reg;
endmodule

// ===== tb/fwrp_top_properties.sv
`timescale 1ns/100ps
// ****************************************************************
// Port-level properties of the protection block.
// ****************************************************************
module fwrp_top_properties
    import fwrp_pkg::*;
(
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic [23:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        cpu_wr_req,
    input wire logic [23:0] cpu_wr_addr,
    input wire logic        flash_wr_req,
    input wire logic [23:0] flash_wr_addr,
    input wire logic        cpu_wr_refused,
    input wire logic        cpu_rd_req,
    input wire logic [23:0] cpu_rd_addr,
    input wire logic        flash_cpu_rd_req,
    input wire logic [23:0] flash_cpu_rd_addr,
    input wire logic        dbg_rd_req,
    input wire logic        flash_dbg_rd_req,
    input wire logic        dbg_rd_refused,
    input wire logic        prog_flash_busy,
    input wire logic        data_flash_busy,
    input wire logic        write_lock_active,
    input wire logic        read_lock_active
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    logic [1:0] age_reg;
    logic       in_flash;

    // Counts edges since reset so the load window is excluded.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) age_reg <= 2'h0;
        else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
    assign in_flash = (cpu_wr_addr <= FWRP_PROG_TOP) ||
                      (cpu_wr_addr >= FWRP_DATA_BASE && cpu_wr_addr <= FWRP_DATA_TOP);

    property p_one_answer;
        cpu_wr_req |=> (flash_wr_req ^ cpu_wr_refused);
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("write answer wrong");
    property p_no_spurious;
        !cpu_wr_req |=> !flash_wr_req && !cpu_wr_refused;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("write without request");
    property p_wr_lock;
        cpu_wr_req && write_lock_active |=> cpu_wr_refused;
    endproperty
    a_wr_lock: assert property (p_wr_lock) else $error("locked write passed");
    property p_outside;
        cpu_wr_req && !in_flash |=> cpu_wr_refused;
    endproperty
    a_outside: assert property (p_outside) else $error("non-flash write passed");
    property p_wr_addr;
        flash_wr_req |-> flash_wr_addr == $past(cpu_wr_addr);
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address lost");
    property p_dbg;
        dbg_rd_req |=> (flash_dbg_rd_req == !$past(read_lock_active)) &&
                       (dbg_rd_refused == $past(read_lock_active));
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug read gating wrong");
    property p_cpu_rd;
        cpu_rd_req |=> flash_cpu_rd_req && flash_cpu_rd_addr == $past(cpu_rd_addr);
    endproperty
    a_cpu_rd: assert property (p_cpu_rd) else $error("cpu read not forwarded");
    property p_lock_hold;
        age_reg == 2'h3 |-> $stable(write_lock_active) && $stable(read_lock_active);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock changed without reset");
    property p_busy;
        reg_rd && reg_addr == FWRP_OFS_STATUS && $stable(prog_flash_busy) &&
        $stable(data_flash_busy) |=> reg_rdata[4:3] ==
        {$past(data_flash_busy), $past(prog_flash_busy | data_flash_busy)} &&
        reg_rdata[15:5] == 11'h000;
    endproperty
    a_busy: assert property (p_busy) else $error("status busy bits wrong");

    c_refused: cover property (cpu_wr_req ##1 cpu_wr_refused);
    c_written: cover property (cpu_wr_req ##1 flash_wr_req);
    c_dbg_block: cover property (dbg_rd_req ##1 dbg_rd_refused);
endmodule

bind fwrp_top fwrp_top_properties u_props (.*);

// ===== tb/test_fwrp_top.sv
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench of the protection block.
// ****************************************************************
module test_fwrp_top;
    import fwrp_pkg::*;
    logic        clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        cpu_wr_req = 1'b0, cpu_rd_req = 1'b0, dbg_rd_req = 1'b0;
    logic [23:0] reg_addr = 24'h0, cpu_wr_addr = 24'h0, cpu_rd_addr = 24'h0;
    logic [23:0] dbg_rd_addr = 24'h0, fwa, fca, fda, a;
    logic [15:0] reg_wdata = 16'h0, cpu_wr_data = 16'h0, prot_word_nv = 16'h0, fwd, rd;
    logic [15:0] lo, hi, dt, reg_rdata;
    logic [2:0]  env = 3'h0;
    logic        fwr, wref, fcr, fdr, dref, wla, rla, pbusy, dbusy, wlock;
    int          num_errors = 0, n_compared = 0;
    localparam logic [15:0] PW_OPEN = 16'h01FF;
    localparam logic [15:0] PW_LOCK = 16'h01CC;

    fwrp_top DUT (.*, .flash_wr_req(fwr), .flash_wr_addr(fwa), .flash_wr_data(fwd),
        .cpu_wr_refused(wref), .flash_cpu_rd_req(fcr), .flash_cpu_rd_addr(fca),
        .flash_dbg_rd_req(fdr), .flash_dbg_rd_addr(fda), .dbg_rd_refused(dref),
        .prog_flash_busy(pbusy), .data_flash_busy(dbusy), .environment_select_inputs(env),
        .write_lock_active(wla), .read_lock_active(rla));
    fwrp_flash_model u_flash (.*, .flash_wr_req(fwr), .flash_wr_addr(fwa),
        .prog_flash_busy(pbusy), .data_flash_busy(dbusy));

    // Free-running 20 MHz clock.
    initial begin
        forever #25 clock = ~clock;
    end

    task automatic give_verdict();
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic compare_word(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic compare_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [23:0] ad, input logic [15:0] d);
        @(posedge clock); reg_addr <= ad; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clock); reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [23:0] ad, output logic [15:0] d);
        @(posedge clock); reg_addr <= ad; reg_rd <= 1'b1;
        @(posedge clock); reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Expected outcome of a CPU write.
    function automatic logic exp_ok(input logic [23:0] ad);
        if (wlock) return 1'b0;
        if (ad <= FWRP_PROG_TOP) return (ad >= 24'h001C00) && (ad[17] ? hi[ad[16:13]] : lo[ad[16:13]]);
        if (ad >= FWRP_DATA_BASE && ad <= FWRP_DATA_TOP) return dt[ad[12:9]];
        return 1'b0;
    endfunction
    function automatic logic [23:0] rand_addr();
        logic [23:0] r;
        r = 24'($urandom);
        if (r[23:22] == 2'h1) return {11'h070, r[12:0]};
        if (r[23:22] == 2'h3) return r;
        return {6'h00, r[17:0]};
    endfunction
    // Software waits for idle arrays before each write.
    task automatic cpu_write(input logic [23:0] ad, input logic exp);
        logic [15:0] d;
        d = 16'($urandom);
        for (int i = 0; i < 20 && (pbusy || dbusy); i++) @(posedge clock);
        @(posedge clock); cpu_wr_req <= 1'b1; cpu_wr_addr <= ad; cpu_wr_data <= d;
        @(posedge clock); cpu_wr_req <= 1'b0;
        #1 compare_flag(fwr, exp);
        compare_flag(wref, !exp);
        if (exp) compare_word({fwa[23:16], fwd}, {ad[23:16], d});
    endtask
    task automatic reads(input logic lock);
        a = 24'($urandom);
        @(posedge clock); dbg_rd_req <= 1'b1; dbg_rd_addr <= a; cpu_rd_req <= 1'b1; cpu_rd_addr <= ~a;
        @(posedge clock); dbg_rd_req <= 1'b0; cpu_rd_req <= 1'b0;
        #1 compare_flag(fdr & (fda == a), !lock);
        compare_flag(dref, lock);
        compare_word(fca, ~a);
        compare_flag(fcr, 1'b1);
    endtask
    task automatic do_reset(input logic [15:0] pw);
        resetn <= 1'b0; prot_word_nv <= pw; env <= 3'($urandom);
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    // Watchdog: the tests need a few thousand cycles at most.
    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end

    // Main sequence: open device, then a locked one after a reset.
    initial begin
        void'($urandom(32'h530dccbb));
        wlock = 1'b0; lo = 16'hFFFF; hi = 16'h0; dt = 16'h0;
        do_reset(PW_OPEN);
        compare_flag(wla | rla, 1'b0);
        for (int i = 0; i < 3; i++) begin
            reg_read(FWRP_OFS_PROG_EN_LOW + 24'(4 * i), rd);
            compare_word(24'(rd), 24'h0);
        end
        cpu_write(24'h004000, 1'b0);
        reg_write(FWRP_OFS_STATUS, 16'hFFFF);
        reg_read(FWRP_OFS_STATUS, rd);
        compare_word(24'(rd), {21'h0, env});
        reg_read(24'hFFF90C, rd);
        compare_word(24'(rd), 24'h0);
        reg_write(FWRP_OFS_PROG_EN_LOW, lo);
        cpu_write(24'h000000, 1'b0);
        cpu_write(24'h001BFF, 1'b0);
        cpu_write(24'h001C00, 1'b1);
        lo = 16'($urandom) | 16'h0001; hi = 16'($urandom); dt = 16'($urandom) | 16'h0001;
        reg_write(FWRP_OFS_PROG_EN_LOW, lo);
        reg_write(FWRP_OFS_PROG_EN_HIGH, hi);
        reg_write(FWRP_OFS_DATA_EN, dt);
        reg_read(FWRP_OFS_PROG_EN_HIGH, rd);
        compare_word(24'(rd), 24'(hi));
        for (int i = 0; i < 150; i++) begin
            a = rand_addr();
            cpu_write(a, exp_ok(a));
        end
        cpu_write(24'h0E0000, 1'b1);
        repeat (2) @(posedge clock);
        reg_read(FWRP_OFS_STATUS, rd);
        compare_word(24'(rd), {19'h0, 2'h3, env});
        cpu_write(24'h001C00, 1'b1);
        repeat (2) @(posedge clock);
        reg_read(FWRP_OFS_STATUS, rd);
        compare_word(24'(rd), {19'h0, 2'h1, env});
        repeat (12) @(posedge clock);
        reg_read(FWRP_OFS_STATUS, rd);
        compare_word(24'(rd), {21'h0, env});
        repeat (10) reads(1'b0);
        prot_word_nv <= PW_LOCK;
        repeat (3) @(posedge clock);
        compare_flag(wla | rla, 1'b0);
        cpu_write(24'h001C00, 1'b1);
        reg_write(FWRP_OFS_PROG_EN_LOW, 16'h0000);
        cpu_write(24'h001C00, 1'b0);
        wlock = 1'b1;
        do_reset(PW_LOCK);
        compare_flag(wla & rla, 1'b1);
        reg_read(FWRP_OFS_DATA_EN, rd);
        compare_word(24'(rd), 24'h0);
        reg_write(FWRP_OFS_PROG_EN_LOW, 16'hFFFF);
        reg_write(FWRP_OFS_DATA_EN, 16'hFFFF);
        for (int i = 0; i < 40; i++) cpu_write(rand_addr(), 1'b0);
        repeat (10) reads(1'b1);
        give_verdict();
    end
endmodule
